// ==== src/dma_irq_pkg.sv ====
package dma_irq_pkg;

    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 32;
    localparam int STRB_W   = DATA_W / 8;
    localparam int NUM_CHAN = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] CHAN_EN_OFF    = 12'h000;
    localparam logic [ADDR_W-1:0] DONE_MASK_OFF  = 12'h008;
    localparam logic [ADDR_W-1:0] DONE_FLAGS_OFF = 12'h00c;
    localparam logic [ADDR_W-1:0] ERR_MASK_OFF   = 12'h010;
    localparam logic [ADDR_W-1:0] ERR_FLAGS_OFF  = 12'h014;
    localparam logic [ADDR_W-1:0] EVT_STAT_OFF   = 12'h018;
    localparam logic [ADDR_W-1:0] EVT_MASK_OFF   = 12'h01c;

    // Values after reset
    localparam logic [DATA_W-1:0] FLAGS_RST   = 32'h0000_0000;
    localparam logic [DATA_W-1:0] MASK_RST    = 32'h0000_0000;
    localparam logic [DATA_W-1:0] CHAN_EN_RST = 32'h0000_0000;

    // Summary event bits
    localparam int EVT_W        = 2;
    localparam int EVT_DONE_BIT = 0;
    localparam int EVT_ERR_BIT  = 1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] wrAddr;
        logic [ADDR_W-1:0] rdAddr;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] strb;
    } regAccess_t;

    function automatic logic regHit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] off);
        return a[ADDR_W-1:2] == off[ADDR_W-1:2];
    endfunction : regHit

    function automatic logic addrMapped(input logic [ADDR_W-1:0] a);
        return regHit(a, CHAN_EN_OFF) || regHit(a, DONE_MASK_OFF)
            || regHit(a, DONE_FLAGS_OFF) || regHit(a, ERR_MASK_OFF)
            || regHit(a, ERR_FLAGS_OFF) || regHit(a, EVT_STAT_OFF)
            || regHit(a, EVT_MASK_OFF);
    endfunction : addrMapped

    function automatic logic [DATA_W-1:0] strbMask(
        input logic [STRB_W-1:0] s);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < STRB_W; i++) begin
            m[i*8 +: 8] = {8{s[i]}};
        end
        return m;
    endfunction : strbMask

endpackage : dma_irq_pkg

// ==== src/sticky_flags.sv ====
module sticky_flags #(
    parameter int N = 32
)(
    input  wire logic         clock,
    input  wire logic         rstn,
    input  wire logic         clockEn,
    input  wire logic [N-1:0] set,
    input  wire logic [N-1:0] clr,
    output logic      [N-1:0] q
);
    import dma_irq_pkg::*;

    // Set beats a clear landing in the same cycle, so no event is lost
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            q <= FLAGS_RST[N-1:0];
        end else if (clockEn) begin
            q <= (q & ~clr) | set;
        end
    end

endmodule : sticky_flags

// ==== src/axil_slave.sv ====
module axil_slave (
    input  wire logic                           clock,
    input  wire logic                           rstn,
    input  wire logic                           clockEn,
    input  wire logic [dma_irq_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                           awvalid,
    output logic                                awready,
    input  wire logic [dma_irq_pkg::DATA_W-1:0] wdata,
    input  wire logic [dma_irq_pkg::STRB_W-1:0] wstrb,
    input  wire logic                           wvalid,
    output logic                                wready,
    output logic      [1:0]                     bresp,
    output logic                                bvalid,
    input  wire logic                           bready,
    input  wire logic [dma_irq_pkg::ADDR_W-1:0] araddr,
    input  wire logic                           arvalid,
    output logic                                arready,
    output logic      [dma_irq_pkg::DATA_W-1:0] rdata,
    output logic      [1:0]                     rresp,
    output logic                                rvalid,
    input  wire logic                           rready,
    output dma_irq_pkg::regAccess_t             acc,
    input  wire logic [dma_irq_pkg::DATA_W-1:0] rdData
);
    import dma_irq_pkg::*;

    logic              awHeld_q;
    logic [ADDR_W-1:0] awAddr_q;
    logic              wHeld_q;
    logic [DATA_W-1:0] wData_q;
    logic [STRB_W-1:0] wStrb_q;
    logic              wrFire;
    logic              rdFire;

    // Address and data may arrive in either order; each is parked
    assign awready = clockEn && !awHeld_q && !bvalid;
    assign wready  = clockEn && !wHeld_q && !bvalid;
    assign arready = clockEn && !rvalid;
    assign wrFire  = clockEn && awHeld_q && wHeld_q && !bvalid;
    assign rdFire  = arvalid && arready;

    assign acc.wr     = wrFire && addrMapped(awAddr_q);
    assign acc.rd     = rdFire && addrMapped(araddr);
    assign acc.wrAddr = awAddr_q;
    assign acc.rdAddr = araddr;
    assign acc.wdata  = wData_q;
    assign acc.strb   = wStrb_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            awHeld_q <= 1'b0;
            awAddr_q <= '0;
        end else if (clockEn) begin
            if (awvalid && awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= awaddr;
            end else if (wrFire) begin
                awHeld_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wHeld_q <= 1'b0;
            wData_q <= '0;
            wStrb_q <= '0;
        end else if (clockEn) begin
            if (wvalid && wready) begin
                wHeld_q <= 1'b1;
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end else if (wrFire) begin
                wHeld_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (clockEn) begin
            if (wrFire) begin
                bvalid <= 1'b1;
                bresp  <= addrMapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Data captured at the address edge: a read-clear cannot lose it
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= RESP_OKAY;
        end else if (clockEn) begin
            if (rdFire) begin
                rvalid <= 1'b1;
                rdata  <= addrMapped(araddr) ? rdData : '0;
                rresp  <= addrMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

endmodule : axil_slave

// ==== src/dma_channel_irq_flags.sv ====
// Operation
// R1 - Each channel has a completion flag at its own bit, set when it finishes.
// R2 - A completion flag reads 1 once the transfer completed, else 0.
// R3 - Completion flags reset to 0; writing 1 clears one, writing 0 keeps it.
// R4 - Each channel has a read/write bus-error mask bit at its own bit, to 31.
// R5 - Bus-error mask bits reset to 0, masking every bus-error interrupt.
// R6 - A bus-error mask bit of 0 blocks that interrupt, 1 lets it through.
// R7 - A set bus-error flag with its mask bit at 1 raises the interrupt.
// R8 - A bus error on a channel sets its bus-error flag and disables it.
// R9 - Each channel has a completion mask bit, reset 0, 1 lets the flag pass.
// R10 - The interrupt is high while any flag is set with its mask bit set.
module dma_channel_irq_flags #(
    parameter int NCH = dma_irq_pkg::NUM_CHAN
)(
    input  wire logic                           clock,
    input  wire logic                           rstn,
    input  wire logic                           clockEn,
    input  wire logic [dma_irq_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                           awvalid,
    output logic                                awready,
    input  wire logic [dma_irq_pkg::DATA_W-1:0] wdata,
    input  wire logic [dma_irq_pkg::STRB_W-1:0] wstrb,
    input  wire logic                           wvalid,
    output logic                                wready,
    output logic      [1:0]                     bresp,
    output logic                                bvalid,
    input  wire logic                           bready,
    input  wire logic [dma_irq_pkg::ADDR_W-1:0] araddr,
    input  wire logic                           arvalid,
    output logic                                arready,
    output logic      [dma_irq_pkg::DATA_W-1:0] rdata,
    output logic      [1:0]                     rresp,
    output logic                                rvalid,
    input  wire logic                           rready,
    input  wire logic [NCH-1:0]                 doneEvt,
    input  wire logic [NCH-1:0]                 busErrEvt,
    output logic      [NCH-1:0]                 chanEnable,
    output logic                                irq
);
    import dma_irq_pkg::*;

    regAccess_t        acc;
    logic [DATA_W-1:0] rdData;
    logic [DATA_W-1:0] wrBits;
    logic [DATA_W-1:0] byteMask;
    logic [NCH-1:0]    chanEn_q;
    logic [NCH-1:0]    chanEn_d;
    logic [NCH-1:0]    doneMask_q;
    logic [NCH-1:0]    errMask_q;
    logic [EVT_W-1:0]  evtMask_q;
    logic [NCH-1:0]    doneFlags;
    logic [NCH-1:0]    errFlags;
    logic [NCH-1:0]    doneClr;
    logic [NCH-1:0]    errClr;
    logic [EVT_W-1:0]  evtFlags;
    logic [EVT_W-1:0]  evtSet;
    logic [EVT_W-1:0]  evtClr;
    logic              irqTerm;
    logic              irq_q;

    axil_slave uBus (
        .clock   (clock),
        .rstn    (rstn),
        .clockEn (clockEn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .acc     (acc),
        .rdData  (rdData)
    );

    function automatic logic wrHit(input regAccess_t a,
                                   input logic [ADDR_W-1:0] off);
        return a.wr && regHit(a.wrAddr, off);
    endfunction : wrHit

    function automatic logic rdHit(input regAccess_t a,
                                   input logic [ADDR_W-1:0] off);
        return a.rd && regHit(a.rdAddr, off);
    endfunction : rdHit

    // Unstrobed byte lanes neither write nor clear
    assign byteMask = strbMask(acc.strb);
    assign wrBits   = acc.wdata & byteMask;

    function automatic logic [NCH-1:0] merge(input logic [NCH-1:0] q,
                                             input logic [DATA_W-1:0] d,
                                             input logic [DATA_W-1:0] m);
        return (q & ~m[NCH-1:0]) | (d[NCH-1:0] & m[NCH-1:0]);
    endfunction : merge

    // Bus error drops the enable even against a same-cycle write
    always_comb begin
        chanEn_d = chanEn_q;
        if (wrHit(acc, CHAN_EN_OFF)) begin
            chanEn_d = merge(chanEn_q, acc.wdata, byteMask);
        end
        chanEn_d = chanEn_d & ~busErrEvt; // [R8]
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            chanEn_q <= CHAN_EN_RST[NCH-1:0];
        end else if (clockEn) begin
            chanEn_q <= chanEn_d;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            doneMask_q <= MASK_RST[NCH-1:0]; // [R9]
        end else if (clockEn && wrHit(acc, DONE_MASK_OFF)) begin
            doneMask_q <= merge(doneMask_q, acc.wdata, byteMask);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            errMask_q <= MASK_RST[NCH-1:0]; // [R5]
        end else if (clockEn && wrHit(acc, ERR_MASK_OFF)) begin
            errMask_q <= merge(errMask_q, acc.wdata, byteMask); // [R4]
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            evtMask_q <= MASK_RST[EVT_W-1:0];
        end else if (clockEn && wrHit(acc, EVT_MASK_OFF)) begin
            evtMask_q <= (evtMask_q & ~byteMask[EVT_W-1:0])
                       | wrBits[EVT_W-1:0];
        end
    end

    assign doneClr = wrHit(acc, DONE_FLAGS_OFF) ? wrBits[NCH-1:0]
                                                : '0; // [R3]
    assign errClr  = wrHit(acc, ERR_FLAGS_OFF) ? wrBits[NCH-1:0] : '0;

    // Completion flags, one per channel at its own bit
    sticky_flags #(.N(NCH)) uDone (
        .clock   (clock),
        .rstn    (rstn),
        .clockEn (clockEn),
        .set     (doneEvt), // [R1]
        .clr     (doneClr),
        .q       (doneFlags)
    );

    sticky_flags #(.N(NCH)) uErr (
        .clock   (clock),
        .rstn    (rstn),
        .clockEn (clockEn),
        .set     (busErrEvt), // [R8]
        .clr     (errClr),
        .q       (errFlags)
    );

    // Summary of any event since last read; reading it clears it
    assign evtSet[EVT_DONE_BIT] = |doneEvt;
    assign evtSet[EVT_ERR_BIT]  = |busErrEvt;
    assign evtClr = rdHit(acc, EVT_STAT_OFF) ? '1 : '0;

    sticky_flags #(.N(EVT_W)) uEvt (
        .clock   (clock),
        .rstn    (rstn),
        .clockEn (clockEn),
        .set     (evtSet),
        .clr     (evtClr),
        .q       (evtFlags)
    );

    always_comb begin
        rdData = '0;
        if (regHit(acc.rdAddr, CHAN_EN_OFF)) begin
            rdData = DATA_W'(chanEn_q);
        end else if (regHit(acc.rdAddr, DONE_MASK_OFF)) begin
            rdData = DATA_W'(doneMask_q);
        end else if (regHit(acc.rdAddr, DONE_FLAGS_OFF)) begin
            rdData = DATA_W'(doneFlags); // [R2]
        end else if (regHit(acc.rdAddr, ERR_MASK_OFF)) begin
            rdData = DATA_W'(errMask_q); // [R4]
        end else if (regHit(acc.rdAddr, ERR_FLAGS_OFF)) begin
            rdData = DATA_W'(errFlags);
        end else if (regHit(acc.rdAddr, EVT_STAT_OFF)) begin
            rdData = DATA_W'(evtFlags);
        end else if (regHit(acc.rdAddr, EVT_MASK_OFF)) begin
            rdData = DATA_W'(evtMask_q);
        end
    end

    // Mask 0 blocks, 1 passes, for every source
    assign irqTerm = |(doneFlags & doneMask_q)            // [R9]
                   | |(errFlags & errMask_q)              // [R6] [R7]
                   | |(evtFlags & evtMask_q);             // [R10]

    // Registered so the pin never glitches while flags settle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else if (clockEn) begin
            irq_q <= irqTerm; // [R10]
        end
    end

    assign irq        = irq_q;
    assign chanEnable = chanEn_q;

    sequence sDoneEvt;
        clockEn && (doneEvt != '0);
    endsequence

    sequence sBusErr;
        clockEn && (busErrEvt != '0);
    endsequence

    sequence sDoneClear;
        clockEn && wrHit(acc, DONE_FLAGS_OFF) && (doneEvt == '0);
    endsequence

    property pDoneSet;
        @(posedge clock) disable iff (!rstn)
        sDoneEvt |=> ((doneFlags & $past(doneEvt)) == $past(doneEvt));
    endproperty

    property pErrDisable;
        @(posedge clock) disable iff (!rstn)
        sBusErr |=> ((errFlags & $past(busErrEvt)) == $past(busErrEvt))
                    && ((chanEn_q & $past(busErrEvt)) == '0);
    endproperty

    chk_done_flag_set: assert property (pDoneSet) // [R1]
        else $error("completion event did not set its flag");

    chk_done_readback: assert property (@(posedge clock) // [R2]
        disable iff (!rstn)
        rdHit(acc, DONE_FLAGS_OFF) && clockEn
        |=> rvalid && (rdata == DATA_W'($past(doneFlags))))
        else $error("completion flags read back wrong");

    chk_done_w1c: assert property (@(posedge clock) // [R3]
        disable iff (!rstn)
        sDoneClear |=> doneFlags
            == ($past(doneFlags) & ~$past(wrBits[NCH-1:0])))
        else $error("write-one-to-clear misbehaved");

    chk_err_mask_write: assert property (@(posedge clock) // [R4]
        disable iff (!rstn)
        clockEn && wrHit(acc, ERR_MASK_OFF) && (acc.strb == '1)
        |=> errMask_q == $past(acc.wdata[NCH-1:0]))
        else $error("bus-error mask write not stored");

    chk_masks_reset: assert property (@(posedge clock) // [R5]
        disable iff (!rstn)
        $rose(rstn) |-> (errMask_q == '0) && (doneMask_q == '0))
        else $error("masks not cleared by reset");

    chk_err_masked: assert property (@(posedge clock) // [R6]
        disable iff (!rstn)
        clockEn && ((doneFlags & doneMask_q) == '0)
        && ((evtFlags & evtMask_q) == '0)
        && ((errFlags & errMask_q) == '0) |=> !irq)
        else $error("masked bus error raised the interrupt");

    chk_err_irq: assert property (@(posedge clock) // [R7]
        disable iff (!rstn)
        clockEn && ((errFlags & errMask_q) != '0) |=> irq)
        else $error("unmasked bus error gave no interrupt");

    chk_err_disable: assert property (pErrDisable) // [R8]
        else $error("bus error did not flag and disable channel");

    chk_done_irq: assert property (@(posedge clock) // [R9]
        disable iff (!rstn)
        clockEn && ((doneFlags & doneMask_q) != '0) |=> irq)
        else $error("unmasked completion gave no interrupt");

    chk_irq_level: assert property (@(posedge clock) // [R10]
        disable iff (!rstn)
        clockEn |=> irq == $past(irqTerm))
        else $error("interrupt level disagrees with flags");

    // A low clock enable must freeze flags, enables and the pin
    chk_freeze_hold: assert property (@(posedge clock) // [R1]
        disable iff (!rstn)
        !clockEn |=> $stable(doneFlags) && $stable(errFlags)
            && $stable(chanEn_q) && $stable(irq))
        else $error("state moved while clock enable was low");

    chk_flags_reset: assert property (@(posedge clock) // [R3]
        disable iff (!rstn)
        $rose(rstn) |-> (doneFlags == '0) && (errFlags == '0))
        else $error("flags not cleared by reset");

    chk_evt_clear: assert property (@(posedge clock) // [R10]
        disable iff (!rstn)
        clockEn && rdHit(acc, EVT_STAT_OFF) && (doneEvt == '0)
            && (busErrEvt == '0) |=> (evtFlags == '0))
        else $error("summary read did not clear its bits");

endmodule : dma_channel_irq_flags

// ==== sim/dma_engine_model.sv ====
module dma_engine_model (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        go,
    input  wire logic [3:0]  lag,
    input  wire logic [31:0] doneReq,
    input  wire logic [31:0] errReq,
    output logic      [31:0] doneEvt,
    output logic      [31:0] busErrEvt,
    output logic             busy
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0]  cnt_q;
    logic [31:0] done_q;
    logic [31:0] err_q;

    // Engines report as one-cycle pulses only, after a variable lag
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            busy      <= 1'b0;
            cnt_q     <= 4'h0;
            done_q    <= 32'h0;
            err_q     <= 32'h0;
            doneEvt   <= 32'h0;
            busErrEvt <= 32'h0;
        end else begin
            doneEvt   <= 32'h0;
            busErrEvt <= 32'h0;
            if (go && !busy) begin
                busy   <= 1'b1;
                cnt_q  <= lag;
                done_q <= doneReq;
                err_q  <= errReq;
            end else if (busy && cnt_q == 4'h0) begin
                busy      <= 1'b0;
                doneEvt   <= done_q;
                busErrEvt <= err_q;
            end else if (busy) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule : dma_engine_model

// ==== sim/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import dma_irq_pkg::*;

    localparam int LIMIT = 20000;
    localparam logic [ADDR_W-1:0] OFFS [7] = '{CHAN_EN_OFF, DONE_MASK_OFF,
        DONE_FLAGS_OFF, ERR_MASK_OFF, ERR_FLAGS_OFF, EVT_STAT_OFF,
        EVT_MASK_OFF};

    logic              clock, rstn, clockEn, go, busy, irq;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [STRB_W-1:0] wstrb;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready;
    logic [1:0]        bresp, rresp;
    logic [3:0]        lag;
    logic [31:0]       doneReq, errReq, doneEvt, busErrEvt, chanEnable;
    logic [31:0]       doneExp, errExp, enExp, evtExp, mD, mE;
    int                miscompares, numChecks, cycleCount;

    dma_channel_irq_flags dma_channel_irq_flags_inst (.clock(clock),
        .rstn(rstn), .clockEn(clockEn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .doneEvt(doneEvt), .busErrEvt(busErrEvt), .chanEnable(chanEnable),
        .irq(irq));

    dma_engine_model dma_engine_model_inst (.clock(clock), .rstn(rstn),
        .go(go), .lag(lag), .doneReq(doneReq), .errReq(errReq),
        .doneEvt(doneEvt), .busErrEvt(busErrEvt), .busy(busy));

    function automatic logic irqExp();
        return |((doneExp & mD) | (errExp & mE));
    endfunction : irqExp

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        numChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t %s: got %h want %h", $time, what, seen,
                     exp);
        end
    endtask : check

    task automatic axiWrite(input logic [ADDR_W-1:0] a,
                            input logic [31:0] d, input logic [3:0] s);
        bit awDone, wDone;
        awDone = 0;
        wDone = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge clock);
            if (!awDone && awready) begin
                awvalid <= 1'b0;
                awDone = 1;
            end
            if (!wDone && wready) begin
                wvalid <= 1'b0;
                wDone = 1;
            end
        end
        do @(posedge clock); while (!bvalid);
    endtask : axiWrite

    task automatic axiRead(input logic [ADDR_W-1:0] a,
                           output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clock); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clock); while (!rvalid);
        d = rdata;
        r = rresp;
    endtask : axiRead

    task automatic fire(input logic [31:0] d, input logic [31:0] e,
                        input logic [3:0] l);
        doneReq <= d;
        errReq <= e;
        lag <= l;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        do @(posedge clock); while (busy);
    endtask : fire

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // A hung handshake ends here instead of running forever
    always @(posedge clock) begin
        cycleCount++;
        if (cycleCount == LIMIT) begin
            miscompares++;
            give_verdict();
        end
    end

    initial begin
        logic [31:0] d, e, c, rd;
        logic [1:0]  rs;
        {rstn, go, awvalid, wvalid, arvalid} = '0;
        {awaddr, araddr, wdata, wstrb, lag, doneReq, errReq} = '0;
        {clockEn, bready, rready} = 3'b111;
        {doneExp, errExp, evtExp, mD, mE} = '0;
        void'($urandom(24));
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        check(32'(irq), 32'h0, "irq after reset");
        foreach (OFFS[i]) begin
            axiRead(OFFS[i], rd, rs);
            check(rd, 32'h0, "reset value");
            check(32'(rs), 32'(RESP_OKAY), "reset resp");
        end
        axiWrite(ERR_MASK_OFF, 32'hffff_ffff, 4'hf);
        axiWrite(ERR_MASK_OFF, 32'h0, 4'h8);
        axiRead(ERR_MASK_OFF, rd, rs);
        check(rd, 32'h00ff_ffff, "mask strobe");
        axiWrite(12'h004, 32'hffff_ffff, 4'hf);
        check(32'(bresp), 32'(RESP_SLVERR), "unmapped write");
        axiRead(12'h004, rd, rs);
        check(rd, 32'h0, "unmapped data");
        check(32'(rs), 32'(RESP_SLVERR), "unmapped resp");
        for (int i = 0; i < 16; i++) begin
            enExp = $urandom;
            axiWrite(CHAN_EN_OFF, enExp, 4'hf);
            d = $urandom & $urandom;
            e = (i == 0) ? 32'h8000_0008 : $urandom & $urandom & $urandom;
            fire(d, e, 4'($urandom_range(5)));
            doneExp |= d;
            errExp |= e;
            enExp &= ~e;
            evtExp |= {30'h0, |e, |d};
            axiRead(DONE_FLAGS_OFF, rd, rs);
            check(rd, doneExp, "done flags");
            axiRead(ERR_FLAGS_OFF, rd, rs);
            check(rd, errExp, "error flags");
            check(chanEnable, enExp, "channel enables");
            mD = (i == 0) ? 32'h0 : $urandom;
            mE = (i == 0) ? 32'h0 : $urandom;
            axiWrite(DONE_MASK_OFF, mD, 4'hf);
            axiWrite(ERR_MASK_OFF, mE, 4'hf);
            axiRead(ERR_MASK_OFF, rd, rs);
            check(rd, mE, "error mask");
            repeat (2) @(posedge clock);
            check(32'(irq), 32'(irqExp()), "irq");
            c = (i == 1) ? 32'h0 : $urandom;
            axiWrite(DONE_FLAGS_OFF, c, 4'hf);
            doneExp &= ~c;
            c = $urandom;
            axiWrite(ERR_FLAGS_OFF, c, 4'hf);
            errExp &= ~c;
            axiRead(DONE_FLAGS_OFF, rd, rs);
            check(rd, doneExp, "after clear");
            axiRead(EVT_STAT_OFF, rd, rs);
            check(rd, evtExp, "event summary");
            evtExp = '0;
            repeat (2) @(posedge clock);
            check(32'(irq), 32'(irqExp()), "irq after clear");
        end
        // Summary mask path alone, then a stretch frozen by clockEn
        mD = '0;
        mE = '0;
        axiWrite(DONE_MASK_OFF, mD, 4'hf);
        axiWrite(ERR_MASK_OFF, mE, 4'hf);
        axiWrite(EVT_MASK_OFF, 32'h1, 4'hf);
        fire(32'h0000_1008, 32'h0, 4'h2);
        doneExp |= 32'h0000_1008;
        repeat (2) @(posedge clock);
        check(32'(irq), 32'h1, "summary irq");
        axiRead(EVT_STAT_OFF, rd, rs);
        check(rd, 32'h1, "summary bits");
        repeat (2) @(posedge clock);
        check(32'(irq), 32'h0, "summary irq cleared");
        clockEn <= 1'b0;
        fire(32'hffff_ffff, 32'hffff_ffff, 4'h1);
        clockEn <= 1'b1;
        axiRead(DONE_FLAGS_OFF, rd, rs);
        check(rd, doneExp, "frozen done flags");
        check(chanEnable, enExp, "frozen enables");
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        check(32'(irq), 32'h0, "irq after second reset");
        axiRead(DONE_FLAGS_OFF, rd, rs);
        check(rd, 32'h0, "flags after second reset");
        axiRead(ERR_MASK_OFF, rd, rs);
        check(rd, 32'h0, "mask after second reset");
        give_verdict();
    end
endmodule : testbench
